// *** rtl/cps_pkg.sv ***
// Purpose: constants and carriers for the clock prescale and sleep controller
// Assumes: 32-bit apb, word registers, 125 MHz mclk
// Notes: offsets are byte addresses
package cps_pkg;
  localparam logic [11:0] CPS_DIV_OFF = 12'h000;
  localparam logic [11:0] CPS_PCR_OFF = 12'h004;
  localparam logic [11:0] CPS_STAT_OFF = 12'h008;
  localparam logic [11:0] CPS_CPU_OFF = 12'h00C;
  localparam int CPS_UNLOCK_BIT = 7;
  localparam int CPS_BROWNOUT_SLEEP_OFF_BIT = 7;
  localparam int CPS_ARM_BIT = 5;
  localparam int CPS_MODE_LSB = 3;
  localparam int CPS_BROWNOUT_SLEEP_OFF_UNLOCK_BIT = 2;
  localparam logic [3:0] CPS_SEL_RST = 4'h0;
  localparam logic [3:0] CPS_SEL_DIV8 = 4'h3;
  localparam logic [3:0] CPS_SEL_MAX = 4'h7;
  localparam logic [2:0] CPS_WIN_CYC = 3'h4;
  localparam logic [1:0] CPS_BROWNOUT_SLEEP_OFF_DLY = 2'h3;
  localparam logic [2:0] CPS_WAKE_HOLD = 3'h4;
  localparam logic [1:0] CPS_MODE_IDLE = 2'h0;
  localparam logic [1:0] CPS_MODE_ADC = 2'h1;
  localparam logic [1:0] CPS_MODE_PDN = 2'h2;
  localparam int CPS_LEGACY_KHZ = 1600;
  localparam int CPS_MCLK_KHZ = 125000;
  // legacy divide: 125 MHz / 1.6 MHz rounded down
  localparam logic [7:0] CPS_LEGACY_DIV = 8'(CPS_MCLK_KHZ / CPS_LEGACY_KHZ);
  localparam logic [15:0] CPS_SLEEP_WAKE_DEF = 16'h0010;
  localparam logic [15:0] CPS_RESET_WAKE_DEF = 16'h0100;

  typedef enum logic [1:0] {CPS_RUN, CPS_SLEEP, CPS_START, CPS_HOLD} cps_state_t;

  // wake sources grouped
  typedef struct packed {
    logic ext_reset;
    logic wdt_reset;
    logic bod_reset;
    logic adc_done;
    logic mem_ready;
    logic external_interrupt_zero_level;
    logic pin_change;
    logic serial_start;
    logic other_irq;
  } cps_wake_t;

  // gated clock enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic pll;
    logic osc;
  } cps_clk_en_t;
endpackage : cps_pkg

// *** rtl/cps_ctrl.sv ***
// Purpose: system clock divider and sleep controller behind an apb slave
// Assumes: one clock mclk, async active-low rstn; cpu pulses sleep_exec
// Notes: divided clocks are one-cycle enables on mclk, not new clocks
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
module cps_ctrl
  import cps_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic divide_by_eight_fuse,
  input wire logic legacy_mode,
  input wire logic adc_enabled,
  input wire logic sleep_exec,
  input wire cps_wake_t wake_in,
  input wire logic [15:0] sleep_wake_cycles,
  input wire logic [15:0] reset_wake_cycles,
  output logic sys_tick,
  output cps_clk_en_t clk_en,
  output logic adc_start,
  output logic brownout_on,
  output logic cpu_halt,
  output logic irq_resume
);
  logic wr, rd;
  logic [3:0] sel_q;
  logic [3:0] act_sel_q;
  logic unlock_q;
  logic [2:0] win_q;
  logic fuse_taken_q;
  logic [7:0] div_cnt_q;
  logic tick;
  logic arm_q;
  logic [1:0] mode_q;
  logic brownout_sleep_off_unlock_q;
  logic [2:0] brownout_sleep_off_unlock_win_q;
  logic brownout_sleep_off_req_q;
  logic [1:0] brownout_sleep_off_dly_q;
  logic brownout_sleep_off_q;
  logic [1:0] brownout_sleep_off_life_q;
  cps_state_t st_q;
  logic [1:0] slp_mode_q;
  logic bod_off_q;
  logic [15:0] wait_q;
  logic [2:0] hold_q;
  logic irq_wake_q;
  logic wake_ok;
  logic [7:0] wdat;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign wdat = pwdata[7:0];
  // single-cycle access phase, never stalls
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(paddr == CPS_DIV_OFF || paddr == CPS_PCR_OFF
                   || paddr == CPS_STAT_OFF || paddr == CPS_CPU_OFF);

  // unlock flag and its four-cycle window
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      unlock_q <= 1'b0;
      win_q <= 3'h0;
    end else if (wr && paddr == CPS_DIV_OFF && unlock_q && !wdat[CPS_UNLOCK_BIT]) begin
      unlock_q <= 1'b0;
      win_q <= 3'h0;
    end else if (unlock_q) begin
      // a rewrite of 0x80 lands here and changes nothing
      if (win_q == CPS_WIN_CYC - 3'h1) begin
        unlock_q <= 1'b0;
        win_q <= 3'h0;
      end else begin
        win_q <= win_q + 3'h1;
      end
    end else if (wr && paddr == CPS_DIV_OFF && wdat == 8'h80) begin
      unlock_q <= 1'b1;
      win_q <= 3'h0;
    end
  end

  // divider select; fuse strap caught on the first clocked edge after release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= CPS_SEL_RST;
      fuse_taken_q <= 1'b0;
    end else if (!fuse_taken_q) begin
      fuse_taken_q <= 1'b1;
      sel_q <= divide_by_eight_fuse ? CPS_SEL_DIV8 : CPS_SEL_RST;
    end else if (wr && paddr == CPS_DIV_OFF && unlock_q && !wdat[CPS_UNLOCK_BIT]) begin
      sel_q <= wdat[3:0];
    end
  end

  // active setting changes only at a tick boundary of the old rate
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      act_sel_q <= CPS_SEL_RST;
      div_cnt_q <= 8'h00;
    end else begin
      if (tick) begin
        // a boundary is the only safe point: a select change never shortens a period
        act_sel_q <= (sel_q > CPS_SEL_MAX) ? act_sel_q : sel_q;
        div_cnt_q <= 8'h00;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  // tick when counter reaches divide-1; legacy forces the fixed rate
  always_comb begin
    if (legacy_mode)
      tick = (div_cnt_q >= CPS_LEGACY_DIV - 8'h01);
    else
      tick = (div_cnt_q >= 8'((9'h001 << act_sel_q) - 9'h001));
  end
  assign sys_tick = tick;

  // processor control fields
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arm_q <= 1'b0;
      mode_q <= CPS_MODE_IDLE;
    end else if (wr && paddr == CPS_PCR_OFF) begin
      arm_q <= wdat[CPS_ARM_BIT];
      mode_q <= wdat[CPS_MODE_LSB +: 2];
    end
  end

  // brownout sleep-off timed sequence
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      brownout_sleep_off_unlock_q <= 1'b0;
      brownout_sleep_off_unlock_win_q <= 3'h0;
      brownout_sleep_off_req_q <= 1'b0;
      brownout_sleep_off_dly_q <= 2'h0;
      brownout_sleep_off_q <= 1'b0;
      brownout_sleep_off_life_q <= 2'h0;
    end else begin
      if (wr && paddr == CPS_PCR_OFF && wdat[CPS_BROWNOUT_SLEEP_OFF_BIT] && wdat[CPS_BROWNOUT_SLEEP_OFF_UNLOCK_BIT]) begin
        brownout_sleep_off_unlock_q <= 1'b1;
        brownout_sleep_off_unlock_win_q <= 3'h0;
      end else if (brownout_sleep_off_unlock_q) begin
        if (wr && paddr == CPS_PCR_OFF && wdat[CPS_BROWNOUT_SLEEP_OFF_BIT]) begin
          brownout_sleep_off_unlock_q <= 1'b0;
          brownout_sleep_off_req_q <= 1'b1;
          brownout_sleep_off_dly_q <= 2'h0;
        end else if (brownout_sleep_off_unlock_win_q == CPS_WIN_CYC - 3'h1) begin
          brownout_sleep_off_unlock_q <= 1'b0;
        end else begin
          brownout_sleep_off_unlock_win_q <= brownout_sleep_off_unlock_win_q + 3'h1;
        end
      end
      // becomes active three cycles later
      if (brownout_sleep_off_req_q) begin
        if (brownout_sleep_off_dly_q == CPS_BROWNOUT_SLEEP_OFF_DLY - 2'h1) begin
          brownout_sleep_off_req_q <= 1'b0;
          brownout_sleep_off_q <= 1'b1;
          brownout_sleep_off_life_q <= 2'h0;
        end else begin
          brownout_sleep_off_dly_q <= brownout_sleep_off_dly_q + 2'h1;
        end
      end
      // self-clears after three cycles
      if (brownout_sleep_off_q) begin
        if (brownout_sleep_off_life_q == CPS_BROWNOUT_SLEEP_OFF_DLY - 2'h1)
          brownout_sleep_off_q <= 1'b0;
        else
          brownout_sleep_off_life_q <= brownout_sleep_off_life_q + 2'h1;
      end
    end
  end

  // wake filter by the mode in force
  always_comb begin
    unique case (slp_mode_q)
      CPS_MODE_IDLE: wake_ok = |wake_in;
      CPS_MODE_ADC: wake_ok = wake_in.ext_reset | wake_in.wdt_reset | wake_in.bod_reset
                      | wake_in.adc_done | wake_in.mem_ready | wake_in.external_interrupt_zero_level
                      | wake_in.pin_change;
      default: wake_ok = wake_in.ext_reset | wake_in.wdt_reset | wake_in.bod_reset
                 | wake_in.serial_start | wake_in.external_interrupt_zero_level | wake_in.pin_change;
    endcase
  end

  // sleep sequencer; registers and memory untouched, clocks gated and brownout off in power-down with sleep-off set
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CPS_RUN;
      slp_mode_q <= CPS_MODE_IDLE;
      bod_off_q <= 1'b0;
      wait_q <= 16'h0000;
      hold_q <= 3'h0;
      irq_wake_q <= 1'b0;
    end else begin
      unique case (st_q)
        CPS_RUN: begin
          if (sleep_exec && arm_q && mode_q != 2'h3) begin
            st_q <= CPS_SLEEP;
            slp_mode_q <= mode_q;
            bod_off_q <= brownout_sleep_off_q && mode_q == CPS_MODE_PDN;
          end
        end
        CPS_SLEEP: begin
          if (wake_ok) begin
            st_q <= CPS_START;
            bod_off_q <= 1'b0;
            irq_wake_q <= ~(wake_in.ext_reset | wake_in.wdt_reset | wake_in.bod_reset);
            wait_q <= bod_off_q ? reset_wake_cycles : sleep_wake_cycles;
          end
        end
        CPS_START: begin
          if (wait_q == 16'h0000) begin
            st_q <= CPS_HOLD;
            hold_q <= 3'h0;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        CPS_HOLD: begin
          if (!irq_wake_q || hold_q == CPS_WAKE_HOLD - 3'h1)
            st_q <= CPS_RUN;
          else
            hold_q <= hold_q + 3'h1;
        end
      endcase
    end
  end

  // conversion start pulse on entry to idle or adc mode
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      adc_start <= 1'b0;
    else
      adc_start <= (st_q == CPS_RUN) && sleep_exec && arm_q && adc_enabled
                   && (mode_q == CPS_MODE_IDLE || mode_q == CPS_MODE_ADC);
  end

  // resume pulse when an interrupt wake hands back to the cpu
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      irq_resume <= 1'b0;
    else
      irq_resume <= (st_q == CPS_HOLD) && irq_wake_q && hold_q == CPS_WAKE_HOLD - 3'h1;
  end

  // domain gating; every enable except osc rides on the divided tick
  always_comb begin
    clk_en.cpu = tick && st_q == CPS_RUN;
    clk_en.flash = tick && st_q == CPS_RUN;
    clk_en.io = tick && (st_q != CPS_SLEEP || slp_mode_q == CPS_MODE_IDLE);
    clk_en.adc = tick && (st_q != CPS_SLEEP || slp_mode_q != CPS_MODE_PDN);
    clk_en.pll = tick && (st_q != CPS_SLEEP || slp_mode_q == CPS_MODE_IDLE);
    clk_en.osc = st_q != CPS_SLEEP || slp_mode_q != CPS_MODE_PDN;
  end
  assign brownout_on = ~bod_off_q;
  assign cpu_halt = st_q != CPS_RUN;

  // read mux; reserved bits read zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        CPS_DIV_OFF: prdata = {24'h0, unlock_q, 3'h0, sel_q};
        CPS_PCR_OFF: prdata = {24'h0, brownout_sleep_off_q, 1'b0, arm_q, mode_q, brownout_sleep_off_unlock_q, 2'h0};
        CPS_STAT_OFF: prdata = {24'h0, act_sel_q, bod_off_q, 1'b0, st_q};
        CPS_CPU_OFF: prdata = {24'h0, 4'h0, legacy_mode, slp_mode_q, irq_wake_q};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  unlock_window_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(unlock_q) |-> ##[1:4] !unlock_q) else $error("unlock open too long");
  unlock_set_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(unlock_q) |-> $past(wr && paddr == CPS_DIV_OFF && wdat == 8'h80))
    else $error("unlock set without exact write");
  sel_locked_a: assert property (@(posedge mclk) disable iff (!rstn)
    $past(fuse_taken_q) && $changed(sel_q) |-> $past(unlock_q)) else $error("select changed while locked");
  rsv_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
    rd && paddr == CPS_DIV_OFF |-> prdata[6:4] == 3'h0) else $error("reserved bits nonzero");
  sleep_arm_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == CPS_RUN ##1 st_q == CPS_SLEEP |-> $past(sleep_exec && arm_q)) else $error("sleep unarmed");
  idle_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == CPS_SLEEP |-> !clk_en.cpu && !clk_en.flash) else $error("cpu clock in sleep");
  pdn_osc_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == CPS_SLEEP && slp_mode_q == CPS_MODE_PDN |-> !clk_en.osc && !clk_en.adc)
    else $error("clock in power-down");
  brownout_sleep_off_life_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(brownout_sleep_off_q) |-> brownout_sleep_off_q [*3] ##1 !brownout_sleep_off_q) else $error("brownout bit life wrong");
  bod_wake_a: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == CPS_SLEEP ##1 st_q == CPS_START |-> brownout_on) else $error("brownout not restored");
  adc_start_a: assert property (@(posedge mclk) disable iff (!rstn)
    adc_start |-> $past(adc_enabled && mode_q != CPS_MODE_PDN)) else $error("bad conversion start");
  cover_div_change_c: cover property (@(posedge mclk) disable iff (!rstn) $changed(act_sel_q));
  cover_pdn_wake_c: cover property (@(posedge mclk) disable iff (!rstn)
    st_q == CPS_SLEEP && slp_mode_q == CPS_MODE_PDN ##1 st_q == CPS_START);
  cover_irq_resume_c: cover property (@(posedge mclk) disable iff (!rstn) irq_resume);
endmodule : cps_ctrl

// *** bench/cps_ctrl_tb_top.sv ***
// Purpose: self-checking bench for the clock prescale and sleep controller
// Assumes: zero-wait apb slave, 125 MHz mclk, short wake delays on the inputs
// Notes: tick gaps are counted in mclk cycles between sys_tick pulses
`timescale 1ns/10ps
module cps_ctrl_tb_top;
  import cps_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fuse = 1'b0;
  logic legacy = 1'b0;
  logic sleep_exec = 1'b0;
  cps_wake_t wake_in = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sys_tick;
  logic adc_start;
  logic brownout_on;
  logic cpu_halt;
  logic irq_resume;
  cps_clk_en_t clk_en;
  int err_count = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;
  int k;
  // per-mode table: control byte, clocks seen, conversions, ignored and waking sources
  logic [7:0] m_ctl [3] = '{8'h20, 8'h28, 8'h30};
  logic [5:0] m_en [3] = '{6'h0F, 6'h05, 6'h00};
  int m_st [3] = '{1, 1, 0};
  logic [8:0] m_no [3] = '{9'h000, 9'h001, 9'h030};
  logic [8:0] m_yes [3] = '{9'h001, 9'h020, 9'h002};

  // free-running master clock
  always #4 mclk = ~mclk;

  cps_ctrl i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .divide_by_eight_fuse(fuse), .legacy_mode(legacy), .adc_enabled(1'b1), .sleep_exec(sleep_exec),
    .wake_in(wake_in), .sleep_wake_cycles(16'h0004), .reset_wake_cycles(16'h0010),
    .sys_tick(sys_tick), .clk_en(clk_en), .adc_start(adc_start), .brownout_on(brownout_on),
    .cpu_halt(cpu_halt), .irq_resume(irq_resume));

  task automatic final_report;
    $display("Checks %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // a spent wait bound is a mismatch and ends the run
  task automatic guard(input bit hit);
    if (hit) begin
      err_count++;
      $display("Error t=%0t wait bound spent", $time);
      final_report();
    end
  endtask : guard

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    guard(i == 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // two-write unlock sequence, second access three cycles after the first; no wake source in between
  task automatic set_div(input logic [7:0] code);
    apb(1'b1, CPS_DIV_OFF, 32'h80);
    apb(1'b1, CPS_DIV_OFF, {24'h0, code});
  endtask : set_div

  task automatic wait_tick;
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (sys_tick === 1'b1) break;
    end
    guard(i == 300);
  endtask : wait_tick

  // skip ticks first since a new rate lands only at an old-rate boundary
  task automatic gap_chk(input int exp);
    int i;
    wait_tick();
    wait_tick();
    wait_tick();
    for (i = 1; i < 300; i++) begin
      @(posedge mclk);
      if (sys_tick === 1'b1) break;
    end
    chk(32'(i), 32'(exp));
  endtask : gap_chk

  // write control, issue the sleep instruction, watch clocks for 16 cycles
  task automatic sleep_go(input logic [7:0] ctl, input logic hlt, input logic [5:0] en, input int ns);
    int i;
    logic [5:0] seen;
    int starts;
    seen = '0;
    starts = 0;
    apb(1'b1, CPS_PCR_OFF, {24'h0, ctl});
    @(posedge mclk);
    sleep_exec <= 1'b1;
    @(posedge mclk);
    sleep_exec <= 1'b0;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      seen = seen | clk_en;
      starts += int'(adc_start === 1'b1);
    end
    chk({31'h0, cpu_halt}, {31'h0, hlt});
    chk({26'h0, seen}, {26'h0, en});
    chk(32'(starts), 32'(ns));
  endtask : sleep_go

  // a source outside the mode's list must leave the core halted
  task automatic nowake(input cps_wake_t w);
    wake_in <= w;
    repeat (20) @(posedge mclk);
    chk({31'h0, cpu_halt}, 32'h1);
    wake_in <= '0;
  endtask : nowake

  // wake and require the resume no sooner than start-up plus hold
  task automatic wake(input cps_wake_t w, input int lo);
    int i;
    @(posedge mclk);
    wake_in <= w;
    for (i = 0; i < 400; i++) begin
      @(posedge mclk);
      if (irq_resume === 1'b1) break;
    end
    guard(i == 400);
    chk(32'(i >= lo), 32'h1);
    wake_in <= '0;
  endtask : wake

  // hang cut well inside the cycle budget
  initial begin
    #600000;
    guard(1'b1);
  end

  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rdchk(CPS_DIV_OFF, 32'h00);
    rdchk(CPS_PCR_OFF, 32'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, CPS_DIV_OFF, 32'h81);
    rdchk(CPS_DIV_OFF, 32'h00);
    apb(1'b1, CPS_DIV_OFF, 32'h80);
    rdchk(CPS_DIV_OFF, 32'h80);
    repeat (3) @(posedge mclk);
    apb(1'b1, CPS_DIV_OFF, 32'h80);
    apb(1'b1, CPS_DIV_OFF, 32'h80);
    @(posedge mclk);
    rdchk(CPS_DIV_OFF, 32'h00);
    apb(1'b1, CPS_DIV_OFF, 32'h05);
    rdchk(CPS_DIV_OFF, 32'h00);
    set_div(8'h72);
    rdchk(CPS_DIV_OFF, 32'h02);
    for (k = 0; k < 8; k++) begin
      set_div(8'(k));
      rdchk(CPS_DIV_OFF, 32'(k));
      gap_chk(1 << k);
    end
    set_div(8'h08);
    rdchk(CPS_DIV_OFF, 32'h08);
    gap_chk(128);
    legacy <= 1'b1;
    gap_chk(int'(CPS_LEGACY_DIV));
    set_div(8'h01);
    gap_chk(int'(CPS_LEGACY_DIV));
    legacy <= 1'b0;
    set_div(8'h00);
    gap_chk(1);
    sleep_go(8'h18, 1'b0, 6'h3F, 0);
    sleep_go(8'h38, 1'b0, 6'h3F, 0);
    for (k = 0; k < 3; k++) begin
      sleep_go(m_ctl[k], 1'b1, m_en[k], m_st[k]);
      chk({31'h0, brownout_on}, 32'h1);
      nowake(m_no[k]);
      wake(m_yes[k], 8);
    end
    apb(1'b1, CPS_PCR_OFF, 32'hB4);
    apb(1'b1, CPS_PCR_OFF, 32'hB0);
    repeat (3) @(posedge mclk);
    sleep_exec <= 1'b1;
    @(posedge mclk);
    sleep_exec <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, brownout_on}, 32'h0);
    wake(9'h002, 20);
    @(posedge mclk);
    chk({31'h0, brownout_on}, 32'h1);
    // second reset with the divide-by-eight fuse programmed
    rstn <= 1'b0;
    fuse <= 1'b1;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rdchk(CPS_DIV_OFF, 32'h03);
    gap_chk(8);
    final_report();
  end
endmodule : cps_ctrl_tb_top
